// [serial_line_mode_control_test.sv]
// Self-checking bench for the line mode control block.
// Assumes slmc_top, its checker and the line model.
`default_nettype none
module serial_line_mode_control_test
    import slmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Stimulus and instances
    // ****************************************
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0;
    logic        bit_tick = 0, sample_tick = 0, core_txd = 1;
    logic        tx_all_sent_flag = 1, core_tx_timeguard = 0;
    logic        core_tx_shifting = 0;
    logic [4:0]  cyc = 0;
    int          mismatches = 0, n_tests = 0;
    wire [31:0]  prdata;
    wire [3:0]   line_mode;
    wire [10:0]  clock_ratio_field;
    wire pready, pslverr, core_rxd, core_tx_enable, core_rx_enable;
    wire rxd_pin, cts_pin, dsr_pin, dcd_pin, ri_pin, txd_pin, rts_pin, dtr_pin;
    always #2.5 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 5'h1;
        bit_tick <= &cyc;
        sample_tick <= cyc[0];
    end
    slmc_top u_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bit_tick(bit_tick), .sample_tick(sample_tick),
        .core_txd(core_txd), .tx_all_sent_flag(tx_all_sent_flag),
        .core_tx_timeguard(core_tx_timeguard),
        .core_tx_shifting(core_tx_shifting), .core_rxd(core_rxd),
        .core_tx_enable(core_tx_enable), .core_rx_enable(core_rx_enable),
        .line_mode(line_mode), .clock_ratio_field(clock_ratio_field),
        .rxd_pin(rxd_pin), .cts_pin(cts_pin), .dsr_pin(dsr_pin),
        .dcd_pin(dcd_pin), .ri_pin(ri_pin), .txd_pin(txd_pin),
        .rts_pin(rts_pin), .dtr_pin(dtr_pin));
    slmc_line_model u_line (.pclk(pclk), .txd_pin(txd_pin),
        .rts_pin(rts_pin), .dtr_pin(dtr_pin), .rxd_pin(rxd_pin),
        .ri_pin(ri_pin), .dsr_pin(dsr_pin), .dcd_pin(dcd_pin),
        .cts_pin(cts_pin));
    // ****************************************
    // Bus and compare tasks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1, a, d, r, e);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        apb(0, a, 0, r, e);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs;
        logic [31:0] r;
        logic        e;
        rd(ADDR_MODE, r);
        check(r, MODE_RESET);
        rd(ADDR_RATIO, r);
        check(r, {21'h0, RATIO_RESET});
        rd(ADDR_IRF, r);
        check(r, {24'h0, IRF_RESET});
        wr(ADDR_IRF, 32'h1a5);
        rd(ADDR_IRF, r);
        check(r, 32'ha5);
        rd(ADDR_CMD, r);
        check(r, 32'h0);
        apb(0, 8'h08, 0, r, e);
        check({r[30:0], e}, 32'h1);
    endtask
    task automatic t_route;
        logic [3:0] tab [4] = '{4'h6, 4'hc, 4'hb, 4'hd};
        for (int m = 0; m < 4; m++) begin
            wr(ADDR_MODE, 32'(m) << MODE_CH_LSB);
            tick(40);
            for (int s = 0; s < 2; s++) begin
                core_txd <= s[0];
                u_line.set_rx(!s[0]);
                tick(6);
                check({txd_pin, core_rxd}, {tab[m][3-2*s], tab[m][2-2*s]});
            end
            core_txd <= 1;
            u_line.set_rx(1);
        end
        check({core_tx_enable, core_rx_enable}, 32'h0);
        wr(ADDR_MODE, 0);
    endtask
    task automatic t_ir;
        int n;
        wr(ADDR_RATIO, 32'h1);
        wr(ADDR_IRF, 32'h4);
        wr(ADDR_MODE, {28'h0, LM_IRDA});
        tick(40);
        for (int p = 0; p < 2; p++) begin
            fork
                u_line.pulse_rx(p ? 10 : 3);
            join_none
            n = 0;
            repeat (60) begin
                @(posedge pclk);
                n += (core_rxd === 1'b0 && sample_tick);
            end
            check(n >= 15 - 15 * !p && n <= 17 * p, 32'h1);
        end
        do @(posedge pclk); while (!bit_tick);
        core_txd <= 0;
        n = 0;
        for (int k = 0; k < 72; k++) begin
            @(posedge pclk);
            n += (txd_pin === 1'b0);
            if (k == 30) core_txd <= 1;
        end
        check(n >= 5 && n <= 6, 32'h1);
        wr(ADDR_MODE, 0);
    endtask
    task automatic t_modem;
        logic [31:0] r;
        logic [1:0]  exp_p = 2'b11;
        wr(ADDR_MODE, {28'h0, LM_MODEM});
        for (int i = 0; i < 5; i++) begin
            wr(ADDR_CMD, i < 4 ? 32'h1 << (CMD_DTR_ON + i) : 32'h3 << 16);
            exp_p[!i[1]] = i[0] | i[2];
            tick(3);
            check({dtr_pin, rts_pin}, exp_p);
        end
        rd(ADDR_STAT, r);
        for (int k = 0; k < 4; k++) begin
            u_line.set_ctl(k, 0);
            tick(5);
            rd(ADDR_STAT, r);
            check(r & 32'hf0f, {20'h0, ~(4'h1 << k), 4'h0, 4'h1 << k});
            rd(ADDR_STAT, r);
            check(r & 32'hf, 32'h0);
            u_line.set_ctl(k, 1);
            tick(5);
            rd(ADDR_STAT, r);
        end
        check(core_tx_enable, 32'h0);
        u_line.set_ctl(3, 0);
        tick(6);
        check(core_tx_enable, 32'h1);
        core_tx_shifting <= 1;
        u_line.set_ctl(3, 1);
        tick(8);
        check(core_tx_enable, 32'h1);
        core_tx_shifting <= 0;
        tick(6);
        check(core_tx_enable, 32'h0);
        u_line.set_ctl(3, 0);
    endtask
    task automatic t_rs485;
        wr(ADDR_MODE, {28'h0, LM_RS485});
        for (int i = 0; i < 4; i++) begin
            tx_all_sent_flag <= i[0];
            core_tx_timeguard <= i[1];
            tick(3);
            check(rts_pin, !i[0] || i[1]);
        end
        tx_all_sent_flag <= 1;
        core_tx_timeguard <= 0;
        core_txd <= 0;
        tick(4);
        check(txd_pin, 32'h0);
        core_txd <= 1;
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1;
        t_regs;
        t_route;
        t_ir;
        t_modem;
        t_rs485;
        results;
    end
    initial begin
        #50us;
        mismatches++;
        results;
    end
endmodule
`default_nettype wire

// [slmc_asserts.sv]
// Port checks for the line mode control block.
// Assumes binding into slmc_top, one clock pclk, reset presetn.
`default_nettype none
module slmc_asserts
    import slmc_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        tx_all_sent_flag,
    input wire logic        core_tx_timeguard,
    input wire logic        core_tx_shifting,
    input wire logic        core_tx_enable,
    input wire logic        core_rx_enable,
    input wire logic [3:0]  line_mode,
    input wire logic [10:0] clock_ratio_field,
    input wire logic        cts_pin,
    input wire logic        rts_pin,
    input wire logic        dtr_pin
);
    // ****************************************
    // Decode and sequences
    // ****************************************
    wire       acc    = psel && penable;
    wire [5:0] wa     = paddr[7:2];
    wire       wr_cmd = acc && pwrite && wa == ADDR_CMD[7:2];
    wire       mapped = wa == ADDR_CMD[7:2] || wa == ADDR_MODE[7:2]
                     || wa == ADDR_STAT[7:2] || wa == ADDR_RATIO[7:2]
                     || wa == ADDR_IRF[7:2];
    wire [3:0]  wd_lm  = pwdata[3:0];
    wire [10:0] wd_rt  = pwdata[10:0];
    wire        rs_drv = !tx_all_sent_flag || core_tx_timeguard;
    wire        not485 = line_mode != LM_RS485;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_dtr_on;
        wr_cmd && pwdata[CMD_DTR_ON] && !pwdata[CMD_DTR_OFF];
    endsequence
    sequence s_rts_off;
        wr_cmd && pwdata[CMD_RTS_OFF] && not485 ##1 not485;
    endsequence
    sequence s_cts_up;
        line_mode == LM_MODEM && cts_pin && !core_tx_shifting;
    endsequence
    // ****************************************
    // Assertions
    // ****************************************
    a_err_decode: assert property (acc |-> pslverr == !mapped)
        else $error("pslverr decode wrong");
    a_err_phase: assert property (pslverr |-> acc)
        else $error("pslverr outside access");
    a_unmapped_zero: assert property (acc && !pwrite && !mapped |-> !prdata)
        else $error("unmapped read not zero");
    a_mode_write: assert property (
        acc && pwrite && wa == ADDR_MODE[7:2] |=> line_mode == $past(wd_lm))
        else $error("line mode not written");
    a_ratio_write: assert property (
        acc && pwrite && wa == ADDR_RATIO[7:2]
        |=> clock_ratio_field == $past(wd_rt))
        else $error("ratio not written");
    a_dtr_assert: assert property (s_dtr_on |-> ##2 !dtr_pin)
        else $error("dtr not driven low");
    a_rts_release: assert property (s_rts_off |=> rts_pin)
        else $error("rts not driven high");
    a_rs485_rts: assert property (
        $past(line_mode) == LM_RS485 |-> rts_pin == $past(rs_drv))
        else $error("rts not tracking tx state");
    a_cts_hold: assert property (s_cts_up [*6] |=> !core_tx_enable)
        else $error("tx not held by cts");
    a_cts_finish: assert property (
        core_tx_shifting ##1 core_tx_enable |=> core_tx_enable)
        else $error("tx stopped mid character");
    a_remote_both: assert property (!core_rx_enable |-> !core_tx_enable)
        else $error("tx on without rx");
endmodule
bind slmc_top slmc_asserts u_asserts (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
    .tx_all_sent_flag(tx_all_sent_flag),
    .core_tx_timeguard(core_tx_timeguard),
    .core_tx_shifting(core_tx_shifting), .core_tx_enable(core_tx_enable),
    .core_rx_enable(core_rx_enable), .line_mode(line_mode),
    .clock_ratio_field(clock_ratio_field), .cts_pin(cts_pin),
    .rts_pin(rts_pin), .dtr_pin(dtr_pin));
`default_nettype wire

// [slmc_ir_filter.sv]
// Infrared receive pulse filter.
// Assumes a synchronised receive level and a 16x bit sample tick.
`default_nettype none
module slmc_ir_filter
    import slmc_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       ce,
    input  wire logic       rx_in,
    input  wire logic [7:0] filter_val,
    input  wire logic       sample_tick,
    output logic            rx_out
);
    // ****************************************
    // Filter state
    // ****************************************
    slmc_irf_state_t state;
    slmc_irf_state_t next_state;
    logic [7:0]      cnt;
    logic [4:0]      low_cnt;
    logic            rx_prev;
    wire             fall    = rx_prev & ~rx_in;
    wire             cnt_end = (cnt == 8'h00);
    wire             low_end = sample_tick &&
                               (low_cnt == IR_BIT_TICKS - 5'h01);

    always_comb begin
        next_state = state;
        case (state)
            SLMC_IRF_IDLE: begin
                if (fall) begin
                    next_state = SLMC_IRF_COUNT;
                end
            end
            SLMC_IRF_COUNT: begin
                if (rx_in) begin
                    next_state = SLMC_IRF_IDLE;
                end else if (cnt_end) begin
                    next_state = SLMC_IRF_LOW;
                end
            end
            SLMC_IRF_LOW: begin
                if (low_end) begin
                    next_state = SLMC_IRF_IDLE;
                end
            end
            default: next_state = SLMC_IRF_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state   <= SLMC_IRF_IDLE;
            cnt     <= IRF_RESET;
            low_cnt <= 5'h00;
            rx_prev <= 1'b1;
            rx_out  <= 1'b1;
        end else if (ce) begin
            state   <= next_state;
            rx_prev <= rx_in;
            if (state == SLMC_IRF_COUNT && !rx_in && !cnt_end) begin
                cnt <= cnt - 8'h01;
            end else if (state != SLMC_IRF_COUNT || rx_in) begin
                cnt <= filter_val;
            end
            if (state != SLMC_IRF_LOW) begin
                low_cnt <= 5'h00;
            end else if (sample_tick) begin
                low_cnt <= low_cnt + 5'h01;
            end
            rx_out  <= (next_state != SLMC_IRF_LOW);
        end
    end
endmodule
`default_nettype wire

// [slmc_line_model.sv]
// Far-side model: modem or transceiver driving the line inputs.
// Assumes pclk of the block; lines rest high, as with pull-ups.
`default_nettype none
module slmc_line_model (
    input  wire logic pclk,
    input  wire logic txd_pin,
    input  wire logic rts_pin,
    input  wire logic dtr_pin,
    output var  logic rxd_pin,
    output wire logic ri_pin,
    output wire logic dsr_pin,
    output wire logic dcd_pin,
    output wire logic cts_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Line drive
    // ****************************************
    logic [3:0] lvl = 4'hf;
    initial rxd_pin = 1'b1;
    assign {cts_pin, dcd_pin, dsr_pin, ri_pin} = lvl;
    task automatic set_ctl(input int k, input logic v);
        @(posedge pclk);
        lvl[k] <= v;
    endtask
    task automatic set_rx(input logic v);
        @(posedge pclk);
        rxd_pin <= v;
    endtask
    task automatic pulse_rx(input int n);
        set_rx(1'b0);
        repeat (n) @(posedge pclk);
        rxd_pin <= 1'b1;
    endtask
endmodule
`default_nettype wire

// [slmc_pkg.sv]
// Constants and types for the serial line mode control block.
// Assumes a character core and baud generator on pclk beside it.
//
// How it works
// - IR receive filter uses an 8-bit down counter loaded from filter reg.
// - Falling edge on receive input starts the counter, one step per clock.
// - Rise before expiry stops the counter and reloads the filter value.
// - Counter at zero drives receiver input low for one bit period.
// - Line mode 0x8 selects IR mode with modulator and demodulator on.
// - IR transmit sends a 3/16 bit pulse per zero, nothing per one.
// - RS485 keeps normal framing with every framing setting usable.
// - In RS485 the request-to-send pin is inverse of all-sent flag.
// - Request-to-send stays high through a programmed transmit timeguard.
// - Modem mode drives DTR and RTS, watches DSR, DCD, CTS and RI.
// - Release command drives DTR or RTS high, assert command low.
// - Change on RI, DSR, DCD or CTS sets its own status change flag.
// - Reading channel status clears the four change flags; code clears only those the read returned, a new change wins.
// - In modem mode CTS high stops transmitter after current character.
// - Normal mode: receive pin to receiver, transmitter to transmit pin.
// - Echo mode copies receive pin to transmit pin, receiver still works.
// - Local loopback feeds transmitter to receiver, transmit pin high.
// - Remote loopback ties receive pin to transmit pin, core disabled.
`default_nettype none
package slmc_pkg;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0]  ADDR_CMD    = 8'h00;
    localparam logic [7:0]  ADDR_MODE   = 8'h04;
    localparam logic [7:0]  ADDR_STAT   = 8'h14;
    localparam logic [7:0]  ADDR_RATIO  = 8'h40;
    localparam logic [7:0]  ADDR_IRF    = 8'h4c;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int          MODE_LM_LSB = 0;
    localparam int          MODE_CH_LSB = 14;
    localparam int          CMD_DTR_ON  = 16;
    localparam int          CMD_DTR_OFF = 17;
    localparam int          CMD_RTS_ON  = 18;
    localparam int          CMD_RTS_OFF = 19;
    localparam int          STAT_FLG_LSB = 0;
    localparam int          STAT_LVL_LSB = 8;
    localparam int          STAT_HOLD   = 12;
    localparam int          RATIO_W     = 11;
    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [31:0] MODE_RESET  = 32'h0000_0000;
    localparam logic [10:0] RATIO_RESET = 11'h174;
    localparam logic [7:0]  IRF_RESET   = 8'h00;
    // ****************************************
    // Line and channel modes
    // ****************************************
    localparam logic [3:0]  LM_NORMAL   = 4'h0;
    localparam logic [3:0]  LM_RS485    = 4'h1;
    localparam logic [3:0]  LM_MODEM    = 4'h3;
    localparam logic [3:0]  LM_IRDA     = 4'h8;
    localparam logic [1:0]  CH_NORMAL   = 2'h0;
    localparam logic [1:0]  CH_ECHO     = 2'h1;
    localparam logic [1:0]  CH_LOCAL    = 2'h2;
    localparam logic [1:0]  CH_REMOTE   = 2'h3;
    // ****************************************
    // Infrared timing in sample ticks
    // ****************************************
    localparam logic [4:0]  IR_BIT_TICKS   = 5'h10;
    localparam logic [3:0]  IR_PULSE_TICKS = 4'h3;
    typedef enum logic [1:0] {
        SLMC_IRF_IDLE,
        SLMC_IRF_COUNT,
        SLMC_IRF_LOW
    } slmc_irf_state_t;
endpackage
`default_nettype wire

// [slmc_top.sv]
// Line mode control: IR, RS485, modem lines and channel test modes.
// Assumes the character core, bit tick and 16x sample tick on pclk.
//
// The placing of the registers and the APB register port are this design's own decisions.
`default_nettype none
module slmc_top
    import slmc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        bit_tick,
    input  wire logic        sample_tick,
    input  wire logic        core_txd,
    input  wire logic        tx_all_sent_flag,
    input  wire logic        core_tx_timeguard,
    input  wire logic        core_tx_shifting,
    output logic             core_rxd,
    output logic             core_tx_enable,
    output logic             core_rx_enable,
    output logic [3:0]       line_mode,
    output logic [10:0]      clock_ratio_field,
    input  wire logic        rxd_pin,
    input  wire logic        cts_pin,
    input  wire logic        dsr_pin,
    input  wire logic        dcd_pin,
    input  wire logic        ri_pin,
    output logic             txd_pin,
    output logic             rts_pin,
    output logic             dtr_pin
);
    // ****************************************
    // Registers
    // ****************************************
    logic [31:0] mode_config_reg;
    logic [10:0] clock_ratio_reg;
    logic [7:0]  infrared_filter_reg;
    logic [3:0]  change_flags;
    logic [1:0]  channel_mode_field_act;
    logic        rts_reg;
    logic        dtr_reg;
    logic        tx_hold;
    logic [3:0]  sub_cnt;
    logic [31:0] next_prdata;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [4:0] pin_meta;
    logic [4:0] pin_sync;
    logic [4:0] pin_prev;
    wire  [4:0] pin_raw = {rxd_pin, cts_pin, dcd_pin, dsr_pin, ri_pin};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta <= 5'h1f;
            pin_sync <= 5'h1f;
            pin_prev <= 5'h1f;
        end else if (ce) begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    wire       rxd_s = pin_sync[4];
    wire       cts_s = pin_sync[3];
    wire [3:0] modem_lvl = pin_sync[3:0];
    wire [3:0] modem_chg = pin_sync[3:0] ^ pin_prev[3:0];

    // ****************************************
    // APB decode
    // ****************************************
    wire [7:0] word_addr = {paddr[7:2], 2'b00};
    wire hit_cmd   = (word_addr == ADDR_CMD);
    wire hit_mode  = (word_addr == ADDR_MODE);
    wire hit_stat  = (word_addr == ADDR_STAT);
    wire hit_ratio = (word_addr == ADDR_RATIO);
    wire hit_irf   = (word_addr == ADDR_IRF);
    wire hit_any   = hit_cmd | hit_mode | hit_stat | hit_ratio | hit_irf;
    wire setup     = psel & ~penable;
    wire access    = psel & penable;
    wire wr_ok     = access & pwrite & hit_any;
    wire wr_mode   = wr_ok & hit_mode;
    wire wr_cmd    = wr_ok & hit_cmd;
    wire wr_ratio  = wr_ok & hit_ratio;
    wire wr_irf    = wr_ok & hit_irf;
    wire rd_stat   = access & ~pwrite & hit_stat;

    assign pready  = 1'b1;
    assign pslverr = access & ~hit_any;

    wire [3:0] lm_field = mode_config_reg[MODE_LM_LSB +: 4];
    wire [1:0] ch_field = mode_config_reg[MODE_CH_LSB +: 2];
    wire mode_irda  = (lm_field == LM_IRDA);
    wire mode_rs485 = (lm_field == LM_RS485);
    wire mode_modem = (lm_field == LM_MODEM);

    // Status word: change flags, live levels, transmit hold
    wire [31:0] stat_word = (32'h0 | ({28'h0, change_flags} << STAT_FLG_LSB)
                            | ({28'h0, modem_lvl} << STAT_LVL_LSB)
                            | ({31'h0, tx_hold} << STAT_HOLD));

    always_comb begin
        next_prdata = 32'h0000_0000;
        if (hit_mode) begin
            next_prdata = mode_config_reg;
        end else if (hit_stat) begin
            next_prdata = stat_word;
        end else if (hit_ratio) begin
            next_prdata = {21'h0, clock_ratio_reg};
        end else if (hit_irf) begin
            next_prdata = {24'h0, infrared_filter_reg};
        end
    end

    // Read data is taken in the setup cycle and held for the access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (ce && setup) begin
            prdata <= pwrite ? 32'h0000_0000 : next_prdata;
        end
    end

    // ****************************************
    // Configuration registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_config_reg     <= MODE_RESET;
            clock_ratio_reg     <= RATIO_RESET;
            infrared_filter_reg <= IRF_RESET;
        end else if (ce) begin
            if (wr_mode) begin
                mode_config_reg <= pwdata;
            end
            if (wr_ratio) begin
                clock_ratio_reg <= pwdata[RATIO_W-1:0];
            end
            if (wr_irf) begin
                infrared_filter_reg <= pwdata[7:0];
            end
        end
    end

    assign line_mode         = lm_field;
    assign clock_ratio_field = clock_ratio_reg;

    // ****************************************
    // Modem control and change flags
    // ****************************************
    // Only flags seen by the read are cleared, a new change wins
    wire [3:0] flag_clr = rd_stat ? prdata[STAT_FLG_LSB +: 4] : 4'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            change_flags <= 4'h0;
            rts_reg      <= 1'b1;
            dtr_reg      <= 1'b1;
            tx_hold      <= 1'b0;
        end else if (ce) begin
            change_flags <= (change_flags & ~flag_clr)
                            | modem_chg;
            if (wr_cmd && pwdata[CMD_DTR_OFF]) begin
                dtr_reg <= 1'b1;
            end else if (wr_cmd && pwdata[CMD_DTR_ON]) begin
                dtr_reg <= 1'b0;
            end
            if (wr_cmd && pwdata[CMD_RTS_OFF]) begin
                rts_reg <= 1'b1;
            end else if (wr_cmd && pwdata[CMD_RTS_ON]) begin
                rts_reg <= 1'b0;
            end
            if (!core_tx_shifting) begin
                tx_hold <= mode_modem & cts_s;
            end
        end
    end

    // ****************************************
    // Line driver and handshake outputs
    // ****************************************
    wire rts_next = mode_rs485 ? (~tx_all_sent_flag
                                  | core_tx_timeguard)
                               : rts_reg;

    // ****************************************
    // Channel mode, applied on bit boundary
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_mode_field_act <= CH_NORMAL;
        end else if (ce && bit_tick) begin
            channel_mode_field_act <= ch_field;
        end
    end

    // ****************************************
    // Infrared modulator
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sub_cnt <= 4'h0;
        end else if (ce) begin
            if (bit_tick) begin
                sub_cnt <= 4'h0;
            end else if (sample_tick && sub_cnt != 4'hf) begin
                sub_cnt <= sub_cnt + 4'h1;
            end
        end
    end

    wire ir_pulse = ~core_txd && (sub_cnt < IR_PULSE_TICKS);
    wire tx_src   = mode_irda ? ~ir_pulse : core_txd;

    // ****************************************
    // Infrared demodulator
    // ****************************************
    logic ir_rx;

    slmc_ir_filter u_ir_filter (
        .pclk        (pclk),
        .presetn     (presetn),
        .ce          (ce),
        .rx_in       (rxd_s),
        .filter_val  (infrared_filter_reg),
        .sample_tick (sample_tick),
        .rx_out      (ir_rx)
    );

    wire rx_src = mode_irda ? ir_rx : rxd_s;

    // ****************************************
    // Test mode routing
    // ****************************************
    logic next_txd;
    logic next_rxd;

    always_comb begin
        next_txd = tx_src;
        next_rxd = rx_src;
        case (channel_mode_field_act)
            CH_NORMAL: begin
                next_txd = tx_src;
                next_rxd = rx_src;
            end
            CH_ECHO: begin
                next_txd = rxd_s;
                next_rxd = rx_src;
            end
            CH_LOCAL: begin
                next_txd = 1'b1;
                next_rxd = core_txd;
            end
            CH_REMOTE: begin
                next_txd = rxd_s;
                next_rxd = 1'b1;
            end
            default: begin
                next_txd = tx_src;
                next_rxd = rx_src;
            end
        endcase
    end

    wire remote = (channel_mode_field_act == CH_REMOTE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txd_pin        <= 1'b1;
            core_rxd       <= 1'b1;
            rts_pin        <= 1'b1;
            dtr_pin        <= 1'b1;
            core_tx_enable <= 1'b0;
            core_rx_enable <= 1'b0;
        end else if (ce) begin
            txd_pin        <= next_txd;
            core_rxd       <= next_rxd;
            rts_pin        <= rts_next;
            dtr_pin        <= dtr_reg;
            core_tx_enable <= ~remote & ~tx_hold;
            core_rx_enable <= ~remote;
        end
    end
endmodule
`default_nettype wire
